// ### core/rqs_result_queue.sv
// How it works
// - queue enable clear: no result enters the queue
// - per-converter select bits 28-24 decide which results are queued
// - every result also lands in its converter's own result register
// - with irq enable and irq mask bit 0 set, interrupt rises once data-ready is set
// - data-ready is hardware-owned and set while any entry is unread
// - data-ready drops after the output word read empties the queue
// - overflow flag sets when a result arrives while the queue is full
// - reading the status word with byte enable 2 set clears the overflow flag
// - entry count shows in bits 15-8
// - bit 7 shows the sign of the output entry
// - bits 2-0 show the converter number of the output entry
// - unimplemented bits 30-29, 6-3 read zero and ignore writes
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`include "rqs_consts.svh"
module rqs_result_queue
	import rqs_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [`RQS_NUM_CONV-1:0] conv_done,
	input wire logic [`RQS_NUM_CONV*`RQS_RES_W-1:0] conv_result,
	output logic irq
);
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	rqs_bus_state_t state;
	logic [31:0] ctrl;
	logic ovf_flag;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	rqs_result_t conv_reg [`RQS_NUM_CONV];
	logic [`RQS_NUM_CONV-1:0] pend;
	rqs_result_t pend_data [`RQS_NUM_CONV];
	logic ready_q;

	// one pending slot per converter so simultaneous completions queue one per cycle
	wire [`RQS_NUM_CONV-1:0] pick;
	wire [`RQS_NUM_CONV-1:0] sel = ctrl[`RQS_SEL_HI:`RQS_SEL_LO];
	wire q_en = ctrl[`RQS_BIT_ENABLE];
	assign pick[0] = pend[0];
	genvar g;
	generate
		for (g = 1; g < `RQS_NUM_CONV; g++) begin : g_pick
			assign pick[g] = pend[g] && !(|pend[g-1:0]);
		end
	endgenerate
	wire [2:0] push_id = pick[1] ? 3'd1 : pick[2] ? 3'd2 : pick[3] ? 3'd3 :
		pick[4] ? 3'd4 : 3'd0;
	wire push = |pend;
	wire rqs_result_t push_data = pend_data[push_id];

	wire is_status = (avs_address == `RQS_IDX_STATUS);
	wire is_output = (avs_address == `RQS_IDX_OUTPUT);
	// index 6 belongs to the irq mask, so only converters 0..3 are readable
	wire is_result = (avs_address >= `RQS_IDX_RESULT0) &&
		(avs_address < `RQS_IDX_IRQ_MASK);
	wire is_imask = (avs_address == `RQS_IDX_IRQ_MASK);
	wire is_istat = (avs_address == `RQS_IDX_IRQ_STATUS);
	wire take = (state == RQS_IDLE) && (avs_read || avs_write);
	wire rd_take = take && avs_read;
	wire wr_take = take && avs_write;
	wire pop = rd_take && is_output;
	wire ovf_clr = rd_take && is_status && avs_byteenable[2];

	rqs_result_t head_data;
	logic [2:0] head_id;
	logic [7:0] count;
	logic overflow;
	rqs_entry_store u_store (
		.clock(clock),
		.rst_n(rst_n),
		.push(push),
		.push_data(push_data),
		.push_id(push_id),
		.pop(pop),
		.head_data(head_data),
		.head_id(head_id),
		.count(count),
		.overflow(overflow)
	);
	wire full_push = push && (count == 8'(`RQS_DEPTH)) && !pop;

	wire ready_now = (count != 8'h00);
	// an empty store holds stale or unwritten words, so the head reads as zero
	wire rqs_result_t head_word = ready_now ? head_data : 16'h0000;
	wire [2:0] head_num = ready_now ? head_id : 3'h0;
	wire [31:0] status_word = {ctrl[31], 2'b00, ctrl[28:23], ready_now, ovf_flag,
		5'b00000, count, head_word[`RQS_RES_W-1], 4'h0, head_num};
	wire [2:0] res_idx = 3'(avs_address - `RQS_IDX_RESULT0);
	wire [31:0] rdata = is_status ? status_word :
		is_output ? {16'h0000, head_word} :
		is_result ? {16'h0000, conv_reg[res_idx]} :
		is_imask ? {30'h0000_0000, irq_mask} :
		is_istat ? {30'h0000_0000, irq_status} : `RQS_ZERO32;

	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wmask = be_mask & `RQS_CTRL_WMASK;
	wire [31:0] next_ctrl = (wr_take && is_status) ?
		((ctrl & ~wmask) | (avs_writedata & wmask)) : ctrl;
	wire ready_rise = ready_now && !ready_q;
	wire irq_ev0 = ready_rise && ctrl[`RQS_BIT_IRQ_EN];
	wire [1:0] events = {full_push, irq_ev0};
	wire [1:0] w1c = (wr_take && is_istat && avs_byteenable[0]) ? avs_writedata[1:0] : 2'b00;
	wire [1:0] next_irq_status = events | (irq_status & ~w1c);

	generate
		for (g = 0; g < `RQS_NUM_CONV; g++) begin : g_conv
			wire rqs_result_t res = conv_result[g*`RQS_RES_W +: `RQS_RES_W];
			wire grab = conv_done[g] && q_en && sel[g];
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					conv_reg[g] <= '0;
					pend[g] <= 1'b0;
					pend_data[g] <= '0;
				end else begin
					if (conv_done[g])
						conv_reg[g] <= res;
					if (grab) begin
						pend[g] <= 1'b1;
						pend_data[g] <= res;
					end else if (pick[g]) begin
						pend[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// control state resets to zero so the queue starts disabled and empty
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `RQS_ZERO32;
			ovf_flag <= 1'b0;
			ready_q <= 1'b0;
			irq_status <= 2'b00;
			irq_mask <= 2'b00;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			ready_q <= ready_now;
			// set wins over the read clear
			ovf_flag <= overflow || (ovf_flag && !ovf_clr);
			irq_status <= next_irq_status;
			if (wr_take && is_imask && avs_byteenable[0])
				irq_mask <= avs_writedata[1:0];
			irq <= |(next_irq_status & irq_mask);
		end
	end

	// one wait cycle, then answer; readdata sampled at the request edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= RQS_IDLE;
			avs_readdata <= `RQS_ZERO32;
			avs_waitrequest <= 1'b1;
		end else begin
			case (state)
				RQS_IDLE: begin
					if (take) begin
						state <= RQS_ANSWER;
						avs_waitrequest <= 1'b0;
						avs_readdata <= avs_read ? rdata : `RQS_ZERO32;
					end else begin
						avs_waitrequest <= 1'b1;
					end
				end
				default: begin
					state <= RQS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end
endmodule

// ### core/rqs_consts.svh
`ifndef RQS_CONSTS_SVH
`define RQS_CONSTS_SVH
// word indices on the avalon slave, byte address is four times the index
`define RQS_IDX_STATUS 3'h0
`define RQS_IDX_OUTPUT 3'h1
`define RQS_IDX_RESULT0 3'h2
`define RQS_IDX_IRQ_STATUS 3'h7
`define RQS_IDX_IRQ_MASK 3'h6
// status word fields
`define RQS_BIT_ENABLE 31
`define RQS_SEL_HI 28
`define RQS_SEL_LO 24
`define RQS_BIT_IRQ_EN 23
`define RQS_BIT_READY 22
`define RQS_BIT_OVERFLOW 21
`define RQS_CNT_HI 15
`define RQS_CNT_LO 8
`define RQS_BIT_SIGN 7
`define RQS_ID_HI 2
`define RQS_ID_LO 0
// writable mask of the status word; bits 30-29 and 22-0 are not writable
`define RQS_CTRL_WMASK 32'h9F80_0000
// geometry
`define RQS_NUM_CONV 5
`define RQS_DEPTH 16
`define RQS_RES_W 16
`define RQS_PTR_W 4
`define RQS_ZERO32 32'h0000_0000
`endif

// ### core/rqs_pkg.sv
package rqs_pkg;
	typedef enum logic [1:0] {
		RQS_IDLE = 2'b00,
		RQS_ANSWER = 2'b01
	} rqs_bus_state_t;
	typedef logic [15:0] rqs_result_t;
endpackage

// ### core/rqs_entry_store.sv
`include "rqs_consts.svh"
// circular store of results with source number; one push and one pop per cycle
module rqs_entry_store
	import rqs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic push,
	input wire rqs_result_t push_data,
	input wire logic [2:0] push_id,
	input wire logic pop,
	output rqs_result_t head_data,
	output logic [2:0] head_id,
	output logic [7:0] count,
	output logic overflow
);
	rqs_result_t mem [`RQS_DEPTH];
	logic [2:0] ids [`RQS_DEPTH];
	logic [`RQS_PTR_W-1:0] wr_ptr;
	logic [`RQS_PTR_W-1:0] rd_ptr;
	wire full = (count == 8'(`RQS_DEPTH));
	wire empty = (count == 8'h00);
	wire do_pop = pop && !empty;
	// a push into a full store drops the oldest entry, count stays at depth
	wire wrap = push && full && !do_pop;
	wire [`RQS_PTR_W-1:0] next_rd_ptr = (do_pop || wrap) ? rd_ptr + 1'b1 : rd_ptr;
	wire [7:0] next_count = (push && !do_pop && !full) ? count + 8'h01 :
		(do_pop && !push) ? count - 8'h01 : count;
	assign overflow = wrap;
	assign head_data = mem[rd_ptr];
	assign head_id = ids[rd_ptr];
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= 8'h00;
		end else begin
			wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end
	// storage has no reset; contents are unread until written
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= push_data;
			ids[wr_ptr] <= push_id;
		end
	end
endmodule

// ### dv/rqs_conv_model.sv
module rqs_conv_model (
	input wire logic clock,
	output logic [4:0] conv_done,
	output logic [79:0] conv_result
);
	timeunit 1ns;
	timeprecision 1ns;
	initial conv_done = 5'h0;
	initial conv_result = '0;
	// one strobe per result; the word goes stale once the strobe drops
	task automatic send(input int g, input logic [15:0] v);
		@(posedge clock);
		conv_done[g] <= 1'b1;
		conv_result[16*g+:16] <= v;
		@(posedge clock);
		conv_done <= 5'h0;
		conv_result[16*g+:16] <= ~v;
		@(posedge clock);
	endtask
endmodule

// ### dv/rqs_result_queue_monitor.sv
module rqs_result_queue_monitor (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	wire rq = avs_read || avs_write;
	wire st = avs_read && !avs_waitrequest && avs_address == 3'h0;
	AST_ANSWER: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer");
	AST_STANDS: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("answer too long");
	AST_IDLE: assert property (!rq |=> avs_waitrequest)
		else $error("answer without request");
	AST_ZERO: assert property (st |-> avs_readdata[30:29] == 2'h0 && avs_readdata[6:3] == 4'h0)
		else $error("unused bits set");
	AST_ID: assert property (st |-> avs_readdata[2:0] < 3'h5)
		else $error("reserved source");
	AST_READY: assert property (st |-> avs_readdata[22] == (avs_readdata[15:8] != 8'h00))
		else $error("ready mismatch");
	AST_COUNT: assert property (st |-> avs_readdata[15:8] <= 8'h10)
		else $error("count above depth");
	AST_RESET: assert property ($rose(resetn) |-> !irq && avs_waitrequest)
		else $error("bad reset state");
endmodule
bind rqs_result_queue rqs_result_queue_monitor i_mon (.clock(clock), .resetn(resetn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// ### dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata, d;
	logic avs_waitrequest, irq;
	logic [4:0] conv_done;
	logic [79:0] conv_result;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	always #50 clock = ~clock;
	rqs_result_queue i_dut (.clock(clock), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .conv_done(conv_done),
		.conv_result(conv_result), .irq(irq));
	rqs_conv_model i_conv (.clock(clock), .conv_done(conv_done), .conv_result(conv_result));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("Error %0t: got %h exp %h", $time, s, e);
		end
	endtask
	// request held until the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] v);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= v;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rc(input logic [2:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(d, e);
	endtask
	task automatic ic(input logic e);
		@(posedge clock);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		rc(3'h0, 32'h0000_0000);
		bus(1'b1, 3'h6, 32'h0000_0001);
		bus(1'b1, 3'h0, 32'hFFFF_FFFF);
		rc(3'h0, 32'h9F80_0000);
		for (int g = 0; g < 5; g++) i_conv.send(g, {g[0], 15'(g)});
		ic(1'b1);
		bus(1'b1, 3'h7, 32'h0000_0001);
		ic(1'b0);
		for (int g = 0; g < 5; g++) begin
			rc(3'h0, {16'h9FC0, 8'(5 - g), g[0], 4'h0, 3'(g)});
			rc(3'h1, {16'h0000, g[0], 15'(g)});
		end
		rc(3'h0, 32'h9F80_0000);
		for (int g = 0; g < 4; g++) rc(3'(2 + g), {16'h0000, g[0], 15'(g)});
		bus(1'b1, 3'h0, 32'h1F00_0000);
		i_conv.send(0, 16'h1234);
		rc(3'h0, 32'h1F00_0000);
		rc(3'h2, 32'h0000_1234);
		bus(1'b1, 3'h0, 32'h9D00_0000);
		i_conv.send(0, 16'h8001);
		rc(3'h7, 32'h0000_0000);
		rc(3'h0, 32'h9D40_0180);
		rc(3'h1, 32'h0000_8001);
		bus(1'b1, 3'h0, 32'h9D80_0000);
		i_conv.send(1, 16'h0055);
		rc(3'h0, 32'h9D80_0000);
		bus(1'b1, 3'h6, 32'h0000_0000);
		// seventeen into sixteen places: the first one is lost
		for (int i = 0; i < 17; i++) i_conv.send(0, 16'(i));
		avs_byteenable <= 4'h3;
		rc(3'h0, 32'h9DE0_1000);
		avs_byteenable <= 4'hF;
		rc(3'h0, 32'h9DE0_1000);
		rc(3'h0, 32'h9DC0_1000);
		rc(3'h1, 32'h0000_0001);
		rc(3'h7, 32'h0000_0003);
		ic(1'b0);
		bus(1'b1, 3'h6, 32'h0000_0002);
		ic(1'b1);
		bus(1'b1, 3'h7, 32'h0000_0003);
		ic(1'b0);
		give_verdict();
	end
endmodule
